// [adcpt_cfg.svh]
// Offsets, field positions, reset values and trigger codes of the pair trigger control
`ifndef ADCPT_CFG_SVH
`define ADCPT_CFG_SVH
`define ADCPT_PINS 12
`define ADCPT_PAIRS 4
`define ADCPT_GENS 4
`define ADCPT_AW 4
`define ADCPT_DW 16
`define ADCPT_OFS_PIN 4'h0
`define ADCPT_OFS_PCLO 4'h1
`define ADCPT_OFS_PCHI 4'h2
`define ADCPT_OFS_READY 4'h3
`define ADCPT_IRQ_BIT 7
`define ADCPT_PEND_BIT 6
`define ADCPT_SWTRG_BIT 5
`define ADCPT_SEL_MSB 4
`define ADCPT_SEL_LSB 0
`define ADCPT_RST_PIN 12'h000
`define ADCPT_RST_SEL 5'h00
`define ADCPT_RST_FLAGS 4'h0
`define ADCPT_TRG_OFF 5'h00
`define ADCPT_TRG_SOFT 5'h01
`define ADCPT_TRG_GLOBAL 5'h02
`define ADCPT_TRG_SPECIAL 5'h03
`define ADCPT_TRG_GEN_BASE 5'h04
`define ADCPT_TRG_TMR1 5'h0C
`define ADCPT_TRG_TMR2 5'h0D
`define ADCPT_TRG_CLIM_BASE 5'h0E
`define ADCPT_TRG_FAULT_BASE 5'h16
`endif

// [adcpt_pkg.sv]
// Types of the pair trigger control
package adcpt_pkg;
`include "adcpt_cfg.svh"

   typedef enum logic [0:0] {
      ADCPT_IDLE = 1'b0,
      ADCPT_BUSY = 1'b1
   } adcpt_phase_e;

   typedef struct packed {
      logic [`ADCPT_PINS-1:0]       pinSel;
      logic [`ADCPT_PAIRS-1:0]      irqEn;
      logic [`ADCPT_PAIRS-1:0]      pend;
      logic [`ADCPT_PAIRS-1:0]      swTrg;
      logic [`ADCPT_PAIRS-1:0][4:0] trgSel;
      logic [`ADCPT_PAIRS-1:0]      ready;
      adcpt_phase_e                 phase;
      logic [1:0]                   active;
      logic                         convStart;
      logic [`ADCPT_PAIRS-1:0]      irq;
      logic [`ADCPT_DW-1:0]         rdData;
   } adcpt_state_s;
endpackage : adcpt_pkg

// [adcpt_trig_select.sv]
// Trigger source selector for one conversion pair
`timescale 1ns/1ps
`include "adcpt_cfg.svh"

module adcpt_trig_select #(
   parameter int GENS = 4
) (
   input  wire logic [4:0]      trgSel,
   input  wire logic            softTrigger,
   input  wire logic            globalSoftTrigger,
   input  wire logic            pwmSpecialEvent,
   input  wire logic [GENS-1:0] pwmGenTrigger,
   input  wire logic            timer1Match,
   input  wire logic            timer2Match,
   input  wire logic [GENS-1:0] pwmCurLimTrigger,
   input  wire logic [GENS-1:0] pwmFaultTrigger,
   output logic                 trigHit
);

   // Fixed codes first, then the three generator banks by offset
   always_comb begin
      case (trgSel)
         `ADCPT_TRG_OFF:     trigHit = 1'b0; // R9
         `ADCPT_TRG_SOFT:    trigHit = softTrigger; // R9
         `ADCPT_TRG_GLOBAL:  trigHit = globalSoftTrigger; // R9
         `ADCPT_TRG_SPECIAL: trigHit = pwmSpecialEvent; // R10
         `ADCPT_TRG_TMR1:    trigHit = timer1Match; // R11
         `ADCPT_TRG_TMR2:    trigHit = timer2Match; // R11
         default:            trigHit = 1'b0; // R19
      endcase
      for (int g = 0; g < GENS; g++) begin
         if (trgSel == 5'(`ADCPT_TRG_GEN_BASE + g)) begin
            trigHit = pwmGenTrigger[g]; // R10
         end
         if (trgSel == 5'(`ADCPT_TRG_CLIM_BASE + g)) begin
            trigHit = pwmCurLimTrigger[g]; // R12
         end
         if (trgSel == 5'(`ADCPT_TRG_FAULT_BASE + g)) begin
            trigHit = pwmFaultTrigger[g]; // R13
         end
      end
   end
endmodule : adcpt_trig_select

// [adcpt_control.sv]
// Pair trigger control: pin setup, pair registers and conversion arbitration
// How it works
// R1 - Set bit makes pin digital, mux grounded
// R2 - Clear bit makes pin analog, sampled
// R3 - Pin register top four bits read zero
// R4 - Pair one irq only when enabled
// R5 - Pair one pending set by trigger, done clears
// R6 - Pair one soft trigger starts deferred conversion
// R7 - Soft trigger bit clears when pending sets
// R8 - Even select bits 4-0, odd 12-8
// R9 - Codes off, own soft, global soft
// R10 - Special event, then PWM generators 1-4
// R11 - Timer one and timer two period match
// R12 - Current-limit triggers of generators 1-4
// R13 - Fault triggers of generators 1-4
// R14 - Pair zero irq only when enabled
// R15 - Pair zero pending set by trigger, done clears
// R16 - Pair zero soft trigger starts deferred conversion
// R17 - High register holds pairs three and two
// R18 - Ready set by data, cleared writing zero
// R19 - Unlisted codes never trigger
// R20 - Pending pairs served lowest first, one each
`timescale 1ns/1ps
`include "adcpt_cfg.svh"

module adcpt_control
   import adcpt_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic [`ADCPT_AW-1:0]    regAddr,
   input  wire logic [`ADCPT_DW-1:0]    regWrData,
   input  wire logic                    regWrEn,
   input  wire logic                    regRdEn,
   output logic [`ADCPT_DW-1:0]         regRdData,
   input  wire logic                    globalSoftTrigger,
   input  wire logic                    pwmSpecialEvent,
   input  wire logic [`ADCPT_GENS-1:0]  pwmGenTrigger,
   input  wire logic                    timer1Match,
   input  wire logic                    timer2Match,
   input  wire logic [`ADCPT_GENS-1:0]  pwmCurLimTrigger,
   input  wire logic [`ADCPT_GENS-1:0]  pwmFaultTrigger,
   input  wire logic                    convDone,
   output logic                         convStart,
   output logic [1:0]                   convPair,
   output logic                         convBusy,
   output logic [`ADCPT_PAIRS-1:0]      pairIrq,
   output logic [`ADCPT_PINS-1:0]       portReadEnable,
   output logic [`ADCPT_PINS-1:0]       muxToGround,
   output logic [`ADCPT_PINS-1:0]       analogSample
);

   localparam int PAIRS = `ADCPT_PAIRS;

   adcpt_state_s     state_reg;
   adcpt_state_s     state_next;
   logic [PAIRS-1:0] trigHit;
   logic [PAIRS-1:0] doneMask;
   logic             convFinish;

   // One selector per pair, each fed by its own select field and soft bit
   genvar gp;
   generate
      for (gp = 0; gp < PAIRS; gp++) begin : g_pair
         adcpt_trig_select #(
            .GENS (`ADCPT_GENS)
         ) u_sel (
            .trgSel            (state_reg.trgSel[gp]),
            .softTrigger       (state_reg.swTrg[gp]),
            .globalSoftTrigger (globalSoftTrigger),
            .pwmSpecialEvent   (pwmSpecialEvent),
            .pwmGenTrigger     (pwmGenTrigger),
            .timer1Match       (timer1Match),
            .timer2Match       (timer2Match),
            .pwmCurLimTrigger  (pwmCurLimTrigger),
            .pwmFaultTrigger   (pwmFaultTrigger),
            .trigHit           (trigHit[gp])
         );
      end
   endgenerate

   // Packs one pair's control byte in register order
   function automatic logic [7:0] pairByte(input adcpt_state_s s, input int p);
      logic [7:0] b;
      b = 8'h00;
      b[`ADCPT_IRQ_BIT] = s.irqEn[p];
      b[`ADCPT_PEND_BIT] = s.pend[p];
      b[`ADCPT_SWTRG_BIT] = s.swTrg[p];
      b[`ADCPT_SEL_MSB:`ADCPT_SEL_LSB] = s.trgSel[p];
      return b;
   endfunction : pairByte

   // A done pulse only counts while a conversion is actually running
   assign convFinish = (state_reg.phase == ADCPT_BUSY) && convDone;
   assign doneMask   = convFinish ? (4'h1 << state_reg.active) : 4'h0;

   // Next-state logic: triggers, register writes, reads, arbitration
   always_comb begin
      logic [7:0] wByte;
      wByte = 8'h00;
      state_next = state_reg;
      state_next.convStart = 1'b0;
      state_next.irq = 4'h0;
      state_next.rdData = 16'h0000;

      // A trigger in the completion cycle keeps the pair pending
      state_next.pend = (state_reg.pend & ~doneMask) | trigHit; // R5 R15
      state_next.swTrg = state_reg.swTrg & ~trigHit; // R7

      // Writes; a soft trigger written now overrides the hardware clear
      if (regWrEn) begin
         if (regAddr == `ADCPT_OFS_PIN) begin
            state_next.pinSel = regWrData[`ADCPT_PINS-1:0];
         end else if (regAddr == `ADCPT_OFS_PCLO || regAddr == `ADCPT_OFS_PCHI) begin
            for (int p = 0; p < PAIRS; p++) begin
               if ((p >= 2) == (regAddr == `ADCPT_OFS_PCHI)) begin
                  wByte = regWrData[(p % 2) * 8 +: 8]; // R8 R17
                  state_next.irqEn[p] = wByte[`ADCPT_IRQ_BIT];
                  state_next.swTrg[p] = wByte[`ADCPT_SWTRG_BIT]; // R6 R16
                  state_next.trgSel[p] = wByte[`ADCPT_SEL_MSB:`ADCPT_SEL_LSB];
               end
            end
         end else if (regAddr == `ADCPT_OFS_READY) begin
            // Writing one leaves a flag alone, zero clears it
            state_next.ready = state_reg.ready & regWrData[PAIRS-1:0]; // R18
         end
      end

      // Reads answer in the next cycle; unmapped addresses read zero
      if (regRdEn) begin
         if (regAddr == `ADCPT_OFS_PIN) begin
            state_next.rdData = {4'h0, state_reg.pinSel}; // R3
         end else if (regAddr == `ADCPT_OFS_PCLO) begin
            state_next.rdData = {pairByte(state_reg, 1), pairByte(state_reg, 0)}; // R8
         end else if (regAddr == `ADCPT_OFS_PCHI) begin
            state_next.rdData = {pairByte(state_reg, 3), pairByte(state_reg, 2)}; // R17
         end else if (regAddr == `ADCPT_OFS_READY) begin
            state_next.rdData = {12'h000, state_reg.ready};
         end
      end

      // One conversion at a time; others wait in their pending flags
      case (state_reg.phase)
         ADCPT_IDLE: begin
            if (|state_reg.pend) begin
               state_next.phase = ADCPT_BUSY;
               state_next.convStart = 1'b1;
               for (int p = PAIRS - 1; p >= 0; p--) begin
                  if (state_reg.pend[p]) begin
                     state_next.active = 2'(p); // R20
                  end
               end
            end
         end
         ADCPT_BUSY: begin
            if (convDone) begin
               state_next.phase = ADCPT_IDLE;
               // Set after the write decode, so the set beats a clear
               state_next.ready[state_reg.active] = 1'b1; // R18
               state_next.irq[state_reg.active] = state_reg.irqEn[state_reg.active]; // R4 R14
            end
         end
         default: begin
            state_next.phase = ADCPT_IDLE;
         end
      endcase
   end

   // State register with synchronous reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= '0;
         state_reg.pinSel <= `ADCPT_RST_PIN;
         state_reg.irqEn <= `ADCPT_RST_FLAGS;
         state_reg.pend <= `ADCPT_RST_FLAGS;
         state_reg.swTrg <= `ADCPT_RST_FLAGS;
         state_reg.ready <= `ADCPT_RST_FLAGS;
         state_reg.trgSel <= {PAIRS{`ADCPT_RST_SEL}};
         state_reg.phase <= ADCPT_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign regRdData      = state_reg.rdData;
   assign convStart      = state_reg.convStart;
   assign convPair       = state_reg.active;
   assign convBusy       = (state_reg.phase == ADCPT_BUSY);
   assign pairIrq        = state_reg.irq;
   assign portReadEnable = state_reg.pinSel; // R1
   assign muxToGround    = state_reg.pinSel; // R1
   assign analogSample   = ~state_reg.pinSel; // R2

   // Pin setup follows a write one cycle later
   AST_PIN_DIGITAL: assert property (@(posedge clk) disable iff (sys_rst) // R1
      regWrEn && regAddr == `ADCPT_OFS_PIN |=>
      {4'h0, portReadEnable} == ($past(regWrData) & 16'h0FFF) && muxToGround == portReadEnable)
      else $error("digital pin setup does not follow write");

   AST_PIN_ANALOG: assert property (@(posedge clk) disable iff (sys_rst) // R2
      regWrEn && regAddr == `ADCPT_OFS_PIN |=>
      {4'h0, analogSample} == (~$past(regWrData) & 16'h0FFF))
      else $error("analog pin setup does not follow write");

   AST_PIN_TOP_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // R3
      regRdEn && regAddr == `ADCPT_OFS_PIN |=> regRdData[15:12] == 4'h0)
      else $error("pin register top bits not zero");

   AST_IRQ_GATE: assert property (@(posedge clk) disable iff (sys_rst) // R4 R14
      convBusy && convDone |=>
      pairIrq == ($past(state_reg.irqEn) & (4'h1 << $past(convPair))))
      else $error("completion interrupt wrong");

   AST_NO_STRAY_IRQ: assert property (@(posedge clk) disable iff (sys_rst) // R4 R14
      !(convBusy && convDone) |=> pairIrq == 4'h0)
      else $error("interrupt without completion");

   AST_PEND_SET: assert property (@(posedge clk) disable iff (sys_rst) // R5 R15
      |trigHit |=> (state_reg.pend & $past(trigHit)) == $past(trigHit))
      else $error("pending not set by trigger");

   AST_PEND_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // R5 R15
      convBusy && convDone && !trigHit[convPair] |=> !state_reg.pend[$past(convPair)])
      else $error("pending not cleared at completion");

   AST_SOFT_START1: assert property (@(posedge clk) disable iff (sys_rst) // R6
      state_reg.trgSel[1] == `ADCPT_TRG_SOFT && state_reg.swTrg[1] |=> state_reg.pend[1])
      else $error("pair one soft trigger ignored");

   AST_SOFT_START0: assert property (@(posedge clk) disable iff (sys_rst) // R16
      state_reg.trgSel[0] == `ADCPT_TRG_SOFT && state_reg.swTrg[0]
      |-> ##[1:600] (convStart && convPair == 2'h0))
      else $error("pair zero soft trigger lost");

   AST_SOFT_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // R7
      |(trigHit & state_reg.swTrg) && !regWrEn |=> (state_reg.swTrg & $past(trigHit)) == 4'h0)
      else $error("soft trigger bit not cleared");

   AST_HIGH_LAYOUT: assert property (@(posedge clk) disable iff (sys_rst) // R8 R17
      regWrEn && regAddr == `ADCPT_OFS_PCHI |=>
      {3'h0, state_reg.trgSel[3], 3'h0, state_reg.trgSel[2]} == ($past(regWrData) & 16'h1F1F))
      else $error("high pair fields misplaced");

   AST_CODE_OFF: assert property (@(posedge clk) disable iff (sys_rst) // R9
      state_reg.trgSel[0] == `ADCPT_TRG_OFF |-> !trigHit[0])
      else $error("disabled pair triggered");

   AST_PWM_GEN: assert property (@(posedge clk) disable iff (sys_rst) // R10
      state_reg.trgSel[1] == 5'h07 |-> trigHit[1] == pwmGenTrigger[3])
      else $error("generator four trigger not routed");

   AST_TIMER: assert property (@(posedge clk) disable iff (sys_rst) // R11
      state_reg.trgSel[1] == `ADCPT_TRG_TMR2 |-> trigHit[1] == timer2Match)
      else $error("timer two trigger not routed");

   AST_CUR_LIMIT: assert property (@(posedge clk) disable iff (sys_rst) // R12
      state_reg.trgSel[1] == 5'h0F |-> trigHit[1] == pwmCurLimTrigger[1])
      else $error("current-limit trigger not routed");

   AST_FAULT: assert property (@(posedge clk) disable iff (sys_rst) // R13
      state_reg.trgSel[1] == 5'h19 |-> trigHit[1] == pwmFaultTrigger[3])
      else $error("fault trigger not routed");

   AST_READY_SET: assert property (@(posedge clk) disable iff (sys_rst) // R18
      convBusy && convDone |=> state_reg.ready[$past(convPair)])
      else $error("ready flag not set");

   AST_READY_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // R18
      regWrEn && regAddr == `ADCPT_OFS_READY && !regWrData[0] && !(convFinish && convPair == 2'h0)
      |=> !state_reg.ready[0])
      else $error("ready flag not cleared by zero");

   AST_UNLISTED: assert property (@(posedge clk) disable iff (sys_rst) // R19
      state_reg.trgSel[0] inside {[5'h08:5'h0B], [5'h12:5'h15], [5'h1A:5'h1F]} |-> !trigHit[0])
      else $error("unlisted code triggered");

   AST_LOWEST_FIRST: assert property (@(posedge clk) disable iff (sys_rst) // R20
      !convBusy && state_reg.pend[0] |=> convStart && convPair == 2'h0)
      else $error("arbitration not lowest first");

   AST_ONE_AT_A_TIME: assert property (@(posedge clk) disable iff (sys_rst) // R20
      convBusy && !convDone |=> !convStart && convBusy)
      else $error("start while converting");
endmodule : adcpt_control

// [adcpt_tb.sv]
// Self-checking bench for the pair trigger control: registers, pins, triggers and arbitration
`timescale 1ns/1ps
`include "adcpt_cfg.svh"

module tb_top;
   logic                    clk               = 1'b0;
   logic                    sys_rst           = 1'b1;
   logic [`ADCPT_AW-1:0]    regAddr           = 4'h0;
   logic [`ADCPT_DW-1:0]    regWrData         = 16'h0000;
   logic                    regWrEn           = 1'b0;
   logic                    regRdEn           = 1'b0;
   logic [`ADCPT_DW-1:0]    regRdData;
   logic                    globalSoftTrigger = 1'b0;
   logic                    pwmSpecialEvent   = 1'b0;
   logic [`ADCPT_GENS-1:0]  pwmGenTrigger     = 4'h0;
   logic                    timer1Match       = 1'b0;
   logic                    timer2Match       = 1'b0;
   logic [`ADCPT_GENS-1:0]  pwmCurLimTrigger  = 4'h0;
   logic [`ADCPT_GENS-1:0]  pwmFaultTrigger   = 4'h0;
   logic                    convDone          = 1'b0;
   logic                    convStart;
   logic [1:0]              convPair;
   logic                    convBusy;
   logic [`ADCPT_PAIRS-1:0] pairIrq;
   logic [`ADCPT_PINS-1:0]  portReadEnable;
   logic [`ADCPT_PINS-1:0]  muxToGround;
   logic [`ADCPT_PINS-1:0]  analogSample;
   int                      mismatches        = 0;
   int                      comparisons       = 0;
   int                      cycles            = 0;
   int                      starts            = 0;
   int                      convs             = 0;

   adcpt_control dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .globalSoftTrigger(globalSoftTrigger),
      .pwmSpecialEvent(pwmSpecialEvent), .pwmGenTrigger(pwmGenTrigger), .timer1Match(timer1Match),
      .timer2Match(timer2Match), .pwmCurLimTrigger(pwmCurLimTrigger), .pwmFaultTrigger(pwmFaultTrigger),
      .convDone(convDone), .convStart(convStart), .convPair(convPair), .convBusy(convBusy),
      .pairIrq(pairIrq), .portReadEnable(portReadEnable), .muxToGround(muxToGround),
      .analogSample(analogSample));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // Start pulses counted at the falling edge, so a pulse during a register access is not lost
   always @(negedge clk) begin
      if (convStart === 1'b1) begin
         starts <= starts + 1;
      end
   end

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrEn   <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn   <= 1'b0;
   endtask : wr

   // Read data stands only in the cycle after the strobe, so it is sampled just there
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1;
      d = regRdData;
   endtask : rd

   // Source index to trigger code: global, special, gens, timers, current-limit, fault
   function automatic logic [4:0] srcCode(input int i);
      if (i == 0) return 5'h02;
      if (i == 1) return 5'h03;
      if (i < 6) return 5'h04 + 5'(i - 2);
      if (i < 8) return 5'h0C + 5'(i - 6);
      if (i < 12) return 5'h0E + 5'(i - 8);
      return 5'h16 + 5'(i - 12);
   endfunction : srcCode

   task automatic fire(input int i, input logic v);
      case (i)
         0: globalSoftTrigger <= v;
         1: pwmSpecialEvent <= v;
         2, 3, 4, 5: pwmGenTrigger[i-2] <= v;
         6: timer1Match <= v;
         7: timer2Match <= v;
         default: if (i < 12) pwmCurLimTrigger[i-8] <= v; else pwmFaultTrigger[i-12] <= v;
      endcase
   endtask : fire

   // Drives every trigger source at once, one assignment per signal
   task automatic fireAll(input logic v);
      globalSoftTrigger <= v;
      pwmSpecialEvent   <= v;
      pwmGenTrigger     <= {4{v}};
      timer1Match       <= v;
      timer2Match       <= v;
      pwmCurLimTrigger  <= {4{v}};
      pwmFaultTrigger   <= {4{v}};
   endtask : fireAll

   // Wait bounded for exactly one new start, check the pair, finish it and check the interrupt pulse
   task automatic conv(input logic [1:0] p, input logic [3:0] irq);
      for (int k = 0; k < 12 && starts == convs; k++) begin
         @(posedge clk);
         #1;
      end
      chk(16'(starts), 16'(convs + 1));
      convs++;
      chk({14'h0, convPair}, {14'h0, p});
      @(posedge clk);
      convDone <= 1'b1;
      @(posedge clk);
      convDone <= 1'b0;
      #1;
      chk({12'h0, pairIrq}, {12'h0, irq});
      chk({15'h0, convBusy}, 16'h0000);
   endtask : conv

   initial begin
      logic [15:0] d;
      bit          hit;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset values, unmapped index reads zero
      rd(`ADCPT_OFS_PIN, d);  chk(d, 16'h0000);
      rd(`ADCPT_OFS_PCLO, d); chk(d, 16'h0000);
      rd(`ADCPT_OFS_PCHI, d); chk(d, 16'h0000);
      rd(4'h9, d);            chk(d, 16'h0000);
      chk({4'h0, analogSample}, 16'h0FFF);
      $display("test reset done");
      // Pin configuration: upper nibble unimplemented
      wr(`ADCPT_OFS_PIN, 16'hFFFF);
      rd(`ADCPT_OFS_PIN, d); chk(d, 16'h0FFF);
      chk({4'h0, portReadEnable}, 16'h0FFF);
      chk({4'h0, muxToGround}, 16'h0FFF);
      chk({4'h0, analogSample}, 16'h0000);
      wr(`ADCPT_OFS_PIN, 16'h00A5);
      rd(`ADCPT_OFS_PIN, d);
      chk({4'h0, analogSample}, 16'h0F5A);
      chk({4'h0, portReadEnable}, 16'h00A5);
      $display("test pins done");
      // Pair zero software trigger with interrupt enabled
      wr(`ADCPT_OFS_PCLO, 16'h00A1);
      rd(`ADCPT_OFS_PCLO, d); chk(d, 16'h00C1);
      conv(2'd0, 4'h1);
      rd(`ADCPT_OFS_PCLO, d); chk(d, 16'h0081);
      rd(`ADCPT_OFS_READY, d); chk(d, 16'h0001);
      wr(`ADCPT_OFS_READY, 16'h0000);
      rd(`ADCPT_OFS_READY, d); chk(d, 16'h0000);
      $display("test soft trigger done");
      // Every hardware source on pair one, interrupt enable alternating
      for (int i = 0; i < 16; i++) begin
         wr(`ADCPT_OFS_PCLO, {i[0], 2'b00, srcCode(i), 8'h00});
         @(posedge clk);
         fire(i, 1'b1);
         @(posedge clk);
         fire(i, 1'b0);
         conv(2'd1, {2'b00, i[0], 1'b0});
      end
      $display("test sources done");
      // Off and unlisted codes ignore every source
      for (int j = 0; j < 3; j++) begin
         d = (j == 0) ? 16'h0000 : (j == 1) ? 16'h0008 : 16'h001F;
         wr(`ADCPT_OFS_PCLO, d);
         @(posedge clk);
         fireAll(1'b1);
         @(posedge clk);
         fireAll(1'b0);
         hit = 0;
         repeat (5) begin
            @(posedge clk);
            #1;
            hit |= (convStart === 1'b1);
         end
         chk({15'h0, hit}, 16'h0000);
         rd(`ADCPT_OFS_PCLO, d); chk(d, (j == 0) ? 16'h0000 : (j == 1) ? 16'h0008 : 16'h001F);
      end
      $display("test unlisted done");
      // Three pairs pending from one global trigger, served lowest first
      wr(`ADCPT_OFS_PCLO, 16'h0002);
      wr(`ADCPT_OFS_PCHI, 16'h8282);
      rd(`ADCPT_OFS_PCHI, d); chk(d, 16'h8282);
      @(posedge clk);
      globalSoftTrigger <= 1'b1;
      @(posedge clk);
      globalSoftTrigger <= 1'b0;
      conv(2'd0, 4'h0);
      rd(`ADCPT_OFS_PCHI, d); chk(d, 16'hC2C2);
      conv(2'd2, 4'h4);
      conv(2'd3, 4'h8);
      rd(`ADCPT_OFS_READY, d); chk(d, 16'h000F);
      $display("test arbitration done");
      print_verdict();
   end
endmodule : tb_top
